/* File: common/vicr_pkg.sv */
// constants and types shared by the vectored interrupt control block
package vicr_pkg;

  // ****************************************************************
  // register port geometry
  // ****************************************************************
  localparam int DW = 8;
  localparam int AW = 12;
  localparam int EXT_N = 3;
  localparam int TABLE_W = 21;
  localparam int UPPER_W = 5;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [AW-1:0] OFF_SHADOW = 12'h376;
  localparam logic [AW-1:0] OFF_LOCK = 12'h459;
  localparam logic [AW-1:0] OFF_ADDR_L = 12'h45a;
  localparam logic [AW-1:0] OFF_ADDR_M = 12'h45b;
  localparam logic [AW-1:0] OFF_ADDR_U = 12'h45c;
  localparam logic [AW-1:0] OFF_BASE_L = 12'h45d;
  localparam logic [AW-1:0] OFF_BASE_M = 12'h45e;
  localparam logic [AW-1:0] OFF_BASE_U = 12'h45f;
  localparam logic [AW-1:0] OFF_GCTL = 12'h4d6;
  localparam logic [AW-1:0] OFF_STATE = 12'h4d7;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 12'h4e0;
  localparam logic [AW-1:0] OFF_IRQ_MASK = 12'h4e1;
  localparam logic [AW-1:0] OFF_CFG = 12'h4e2;
  localparam logic [AW-1:0] OFF_KEY = 12'h4e3;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int GCTL_HIGH_BIT = 7;
  localparam int GCTL_LOW_BIT = 6;
  localparam int GCTL_PRIO_BIT = 5;
  localparam int STATE_LSB = 6;
  localparam int LOCK_BIT = 0;
  localparam int SHADOW_BIT = 0;
  localparam int CFG_MVEC_BIT = 0;
  localparam int CFG_ONEWAY_BIT = 1;
  localparam logic [EXT_N-1:0] EDGE_RESET = 3'h7;
  localparam logic [EXT_N-1:0] MASK_RESET = 3'h0;
  localparam logic SHADOW_RESET = 1'b0;
  localparam logic [DW-1:0] KEY_FIRST = 8'h55;
  localparam logic [DW-1:0] KEY_SECOND = 8'haa;
  localparam logic [TABLE_W-1:0] FIXED_VECTOR = 21'h000008;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    CTX_MAIN,
    CTX_LOW,
    CTX_HIGH_MAIN,
    CTX_HIGH_LOW
  } vicr_ctx_type;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } vicr_bus_type;

  typedef struct packed {
    logic take_high;
    logic take_low;
    logic [TABLE_W-1:0] addr;
  } vicr_vec_type;

endpackage : vicr_pkg

/* File: hw/vicr_core.sv */
// vectored interrupt control and status registers
//
// Behaviour
// RULE1: with table mode and priority levels both off every interrupt vectors to 0008h.
// RULE2: with priority levels off bit 7 set permits enabled interrupts, clear blocks all.
// RULE3: with priority levels on bit 7 permits high-priority ones and clear blocks all.
// RULE4: low-priority interrupts need both bit 6 and bit 7 set with levels on.
// RULE5: with priority levels off bit 6 reads back as zero.
// RULE6: bit 5 set gives two priority levels, clear makes every interrupt high priority.
// RULE7: bits 2..0 pick rising (1) or falling (0) edge per external input, reset to one.
// RULE8: bits 7:6 of the state register report main, low, high from main, high over low.
// RULE9: the table base is 21 read/write bits in three bytes, zero after reset.
// RULE10: the current table address is 21 read-only bits, zero after reset.
// RULE11: while the lock bit is set writes to the base bytes are dropped.
// RULE12: the lock bit changes only right after the unlock sequence.
// RULE13: with the one-way option set the lock bit cannot be cleared until reset.
// RULE14: the shadow selector picks main context at 1 and low-priority context at 0.
// RULE15: with table mode off the table is unused and legacy vectors are given.
// RULE16: a selected edge on an external input sets its flag, cleared by software.
// RULE17: unlock is key 55h then key aah on consecutive cycles to the key register.
`timescale 1ns/1ps

module vicr_core
  import vicr_pkg::*;
#(
  parameter int PERIPH_N = 8,
  parameter logic [TABLE_W-1:0] LEGACY_LOW_VEC = 21'h000018
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // register port
  input wire vicr_bus_type bus_in,
  output logic [DW-1:0] rdata_out,
  // external interrupt inputs
  input wire logic [EXT_N-1:0] ext_pin_in,
  input wire logic [EXT_N-1:0] ext_high_in,
  // peripheral requests
  input wire logic [PERIPH_N-1:0] periph_req_in,
  input wire logic [PERIPH_N-1:0] periph_high_in,
  // cpu sequencing
  input wire logic ack_in,
  input wire logic ret_in,
  output vicr_vec_type vec_out,
  output vicr_ctx_type ctx_out,
  output logic shadow_main_out,
  output logic irq_out
);

  localparam int SRC_N = PERIPH_N + EXT_N;
  localparam int IW = $clog2(SRC_N);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic gie_high_r;
  logic gie_low_r;
  logic prio_on_r;
  logic [EXT_N-1:0] edge_sel_r;
  logic [TABLE_W-1:0] base_r;
  logic [TABLE_W-1:0] tbl_addr_r;
  logic lock_r;
  logic one_way_r;
  logic mvec_r;
  logic shadow_r;
  logic [EXT_N-1:0] flag_r;
  logic [EXT_N-1:0] mask_r;
  logic [EXT_N-1:0] pin_prev_r;
  logic primed_r;
  logic key_first_r;
  logic armed_r;
  vicr_ctx_type ctx_r;
  vicr_vec_type vec_r;
  vicr_vec_type vec_nxt;
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;
  logic irq_r;

  // ****************************************************************
  // access decode
  // ****************************************************************
  logic wr_gctl, wr_lock, wr_key, wr_cfg, wr_mask, wr_shadow;
  logic wr_base_l, wr_base_m, wr_base_u, rd_stat;
  logic [EXT_N-1:0] edge_w;
  logic legacy_w;

  assign wr_gctl = bus_in.wr && bus_in.addr == OFF_GCTL;
  assign wr_lock = bus_in.wr && bus_in.addr == OFF_LOCK;
  assign wr_key = bus_in.wr && bus_in.addr == OFF_KEY;
  assign wr_cfg = bus_in.wr && bus_in.addr == OFF_CFG;
  assign wr_mask = bus_in.wr && bus_in.addr == OFF_IRQ_MASK;
  assign wr_shadow = bus_in.wr && bus_in.addr == OFF_SHADOW;
  assign wr_base_l = bus_in.wr && bus_in.addr == OFF_BASE_L;
  assign wr_base_m = bus_in.wr && bus_in.addr == OFF_BASE_M;
  assign wr_base_u = bus_in.wr && bus_in.addr == OFF_BASE_U;
  assign rd_stat = bus_in.rd && bus_in.addr == OFF_IRQ_STAT;
  assign legacy_w = !mvec_r && !prio_on_r;

  // ****************************************************************
  // global control
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      gie_high_r <= 1'b0;
      gie_low_r <= 1'b0;
      prio_on_r <= 1'b0;
      edge_sel_r <= EDGE_RESET; // RULE7
    end else if (wr_gctl) begin
      gie_high_r <= bus_in.wdata[GCTL_HIGH_BIT];
      gie_low_r <= bus_in.wdata[GCTL_LOW_BIT];
      prio_on_r <= bus_in.wdata[GCTL_PRIO_BIT];
      edge_sel_r <= bus_in.wdata[EXT_N-1:0];
    end
  end

  // ****************************************************************
  // table base, guarded by the lock
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      base_r <= '0; // RULE9
    end else if (!lock_r) begin // RULE11
      if (wr_base_l) begin
        base_r[7:0] <= bus_in.wdata;
      end
      if (wr_base_m) begin
        base_r[15:8] <= bus_in.wdata;
      end
      if (wr_base_u) begin
        base_r[TABLE_W-1:16] <= bus_in.wdata[UPPER_W-1:0];
      end
    end
  end

  // ****************************************************************
  // unlock keys and lock bit
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      key_first_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      key_first_r <= wr_key && bus_in.wdata == KEY_FIRST; // RULE17
      armed_r <= wr_key && bus_in.wdata == KEY_SECOND && key_first_r;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      lock_r <= 1'b0;
    end else if (wr_lock && armed_r) begin // RULE12
      if (bus_in.wdata[LOCK_BIT] || !(one_way_r && lock_r)) begin // RULE13
        lock_r <= bus_in.wdata[LOCK_BIT];
      end
    end
  end

  // ****************************************************************
  // configuration and shadow selector
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      mvec_r <= 1'b0;
      one_way_r <= 1'b0;
    end else if (wr_cfg) begin
      mvec_r <= bus_in.wdata[CFG_MVEC_BIT];
      one_way_r <= one_way_r | bus_in.wdata[CFG_ONEWAY_BIT];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      shadow_r <= SHADOW_RESET;
    end else if (wr_shadow) begin
      shadow_r <= bus_in.wdata[SHADOW_BIT]; // RULE14
    end
  end

  // ****************************************************************
  // external edge detection and sticky flags
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < EXT_N; g++) begin : g_edge
      assign edge_w[g] = primed_r && (edge_sel_r[g] ?
        (ext_pin_in[g] && !pin_prev_r[g]) :
        (!ext_pin_in[g] && pin_prev_r[g])); // RULE7
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      pin_prev_r <= '0;
      primed_r <= 1'b0;
    end else begin
      pin_prev_r <= ext_pin_in;
      primed_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      flag_r <= '0;
    end else begin
      flag_r <= (rd_stat ? '0 : flag_r) | edge_w; // RULE16
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      mask_r <= MASK_RESET;
    end else if (wr_mask) begin
      mask_r <= bus_in.wdata[EXT_N-1:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(((rd_stat ? '0 : flag_r) | edge_w) & mask_r);
    end
  end

  // ****************************************************************
  // request selection and vector
  // ****************************************************************
  function automatic logic [IW-1:0] first_set(input logic [SRC_N-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IW'(i);
      end
    end
    return r;
  endfunction : first_set

  logic [SRC_N-1:0] src_w, eff_high_w, hp_w, lp_w;
  logic can_high_w, can_low_w;

  assign src_w = {periph_req_in, flag_r & mask_r};
  assign eff_high_w = {periph_high_in, ext_high_in} |
    {SRC_N{!prio_on_r}}; // RULE6
  assign hp_w = src_w & eff_high_w;
  assign lp_w = src_w & ~eff_high_w;
  assign can_high_w = gie_high_r && ctx_r != CTX_HIGH_MAIN &&
    ctx_r != CTX_HIGH_LOW; // RULE2 RULE3
  assign can_low_w = prio_on_r && gie_high_r && gie_low_r &&
    ctx_r == CTX_MAIN; // RULE4

  always_comb begin
    logic [IW-1:0] idx;
    idx = '0;
    vec_nxt = '0;
    if (!ack_in) begin
      if (can_high_w && |hp_w) begin
        vec_nxt.take_high = 1'b1;
        idx = first_set(hp_w);
      end else if (can_low_w && |lp_w) begin
        vec_nxt.take_low = 1'b1;
        idx = first_set(lp_w);
      end
    end
    if (legacy_w) begin
      vec_nxt.addr = FIXED_VECTOR; // RULE1
    end else if (!mvec_r) begin
      vec_nxt.addr = vec_nxt.take_low ? LEGACY_LOW_VEC : FIXED_VECTOR; // RULE15
    end else begin
      vec_nxt.addr = TABLE_W'(base_r + (TABLE_W'(idx) << 1));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      vec_r <= '0;
    end else begin
      vec_r <= vec_nxt;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      tbl_addr_r <= '0; // RULE10
    end else if (ack_in && mvec_r && (vec_r.take_high || vec_r.take_low)) begin
      tbl_addr_r <= vec_r.addr;
    end
  end

  // ****************************************************************
  // execution context
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ctx_r <= CTX_MAIN;
    end else if (ack_in && (vec_r.take_high || vec_r.take_low)) begin
      case (ctx_r) // RULE8
        CTX_MAIN: begin
          ctx_r <= vec_r.take_high ? CTX_HIGH_MAIN : CTX_LOW;
        end
        CTX_LOW: begin
          ctx_r <= CTX_HIGH_LOW;
        end
        default: begin
          ctx_r <= ctx_r;
        end
      endcase
    end else if (ret_in) begin
      case (ctx_r)
        CTX_HIGH_LOW: begin
          ctx_r <= CTX_LOW;
        end
        default: begin
          ctx_r <= CTX_MAIN;
        end
      endcase
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    rdata_nxt = '0;
    case (bus_in.addr)
      OFF_GCTL: begin
        rdata_nxt[GCTL_HIGH_BIT] = gie_high_r;
        rdata_nxt[GCTL_LOW_BIT] = gie_low_r && prio_on_r; // RULE5
        rdata_nxt[GCTL_PRIO_BIT] = prio_on_r;
        rdata_nxt[EXT_N-1:0] = edge_sel_r;
      end
      OFF_STATE: rdata_nxt[STATE_LSB+1:STATE_LSB] = ctx_r; // RULE8
      OFF_BASE_L: rdata_nxt = base_r[7:0];
      OFF_BASE_M: rdata_nxt = base_r[15:8];
      OFF_BASE_U: rdata_nxt[UPPER_W-1:0] = base_r[TABLE_W-1:16];
      OFF_ADDR_L: rdata_nxt = tbl_addr_r[7:0];
      OFF_ADDR_M: rdata_nxt = tbl_addr_r[15:8];
      OFF_ADDR_U: rdata_nxt[UPPER_W-1:0] = tbl_addr_r[TABLE_W-1:16];
      OFF_LOCK: rdata_nxt[LOCK_BIT] = lock_r;
      OFF_SHADOW: rdata_nxt[SHADOW_BIT] = shadow_r;
      OFF_IRQ_STAT: rdata_nxt[EXT_N-1:0] = flag_r;
      OFF_IRQ_MASK: rdata_nxt[EXT_N-1:0] = mask_r;
      OFF_CFG: begin
        rdata_nxt[CFG_MVEC_BIT] = mvec_r;
        rdata_nxt[CFG_ONEWAY_BIT] = one_way_r;
      end
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rdata_r <= '0;
    end else if (bus_in.rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign vec_out = vec_r;
  assign ctx_out = ctx_r;
  assign shadow_main_out = shadow_r;
  assign irq_out = irq_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence key_pair_s;
    wr_key && bus_in.wdata == KEY_FIRST ##1
      wr_key && bus_in.wdata == KEY_SECOND;
  endsequence

  sequence rise0_s;
    primed_r && edge_sel_r[0] && ext_pin_in[0] && !pin_prev_r[0];
  endsequence

  chk_fixed_vector: assert property ( // RULE1
    vec_out.take_high && $past(legacy_w) |-> vec_out.addr == FIXED_VECTOR)
    else $error("legacy vector not fixed");

  chk_global_block: assert property ( // RULE2
    !gie_high_r ##1 !gie_high_r |-> !vec_out.take_high && !vec_out.take_low)
    else $error("interrupt offered while globally blocked");

  chk_low_needs_both: assert property ( // RULE4
    vec_out.take_low |-> $past(gie_low_r && gie_high_r && prio_on_r))
    else $error("low request without both enables");

  chk_low_reads_zero: assert property ( // RULE5
    bus_in.rd && bus_in.addr == OFF_GCTL && !prio_on_r
      |=> !rdata_out[GCTL_LOW_BIT])
    else $error("low enable not read as zero");

  chk_prio_off_high: assert property ( // RULE6
    $past(!prio_on_r) |-> !vec_out.take_low)
    else $error("low request with levels off");

  chk_edge_sets_flag: assert property ( // RULE16
    rise0_s |=> flag_r[0] ##1 (flag_r[0] || $past(rd_stat)))
    else $error("edge did not set flag");

  chk_state_path: assert property ( // RULE8
    ack_in && vec_out.take_low && ctx_r == CTX_MAIN |=> ctx_out == CTX_LOW)
    else $error("context not entered from main");

  chk_base_locked: assert property ( // RULE11
    lock_r && (wr_base_l || wr_base_m || wr_base_u) |=> $stable(base_r))
    else $error("locked base written");

  chk_lock_needs_key: assert property ( // RULE12
    !armed_r |=> $stable(lock_r))
    else $error("lock changed without unlock");

  chk_key_unlock: assert property ( // RULE17
    key_pair_s ##1 wr_lock && !one_way_r |=> lock_r == $past(bus_in.wdata[0]))
    else $error("unlock sequence not honoured");

  chk_one_way: assert property ( // RULE13
    one_way_r && lock_r |=> lock_r)
    else $error("one-way lock cleared");

  chk_table_ro: assert property ( // RULE10
    !ack_in |=> $stable(tbl_addr_r))
    else $error("table address moved without ack");

endmodule : vicr_core

/* File: sim/vicr_cpu_model.sv */
// cpu side model: takes an offered vector after a chosen number of cycles
`timescale 1ns/1ps

module vicr_cpu_model
  import vicr_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // vector offer and answer
  input wire vicr_vec_type vec_in,
  input wire logic [1:0] wait_in,
  output logic ack_out
);
  // ****************************************************************
  // acknowledge
  // ****************************************************************
  logic ack_r;
  logic [1:0] cnt_r;

  // ack is raised only while an offer stands and lasts one cycle
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ack_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (ack_r) begin
      ack_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (vec_in.take_high | vec_in.take_low) begin
      if (cnt_r >= wait_in) begin
        ack_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end else begin
      cnt_r <= 2'h0;
    end
  end

  assign ack_out = ack_r;
endmodule : vicr_cpu_model

/* File: sim/vicr_core_tb.sv */
// self-checking bench of the vectored interrupt control block
`timescale 1ns/1ps

module vicr_core_tb;
  import vicr_pkg::*;
  localparam logic [TABLE_W-1:0] LOW_VEC = 21'h000018;
  logic mclk_in, nrst_r, ret_r, ack_w, shm_w, irq_w;
  vicr_bus_type bus_r;
  logic [EXT_N-1:0] pin_r, ehi_r;
  logic [7:0] preq_r, phi_r, rdata_w;
  logic [1:0] wait_r;
  vicr_vec_type vec_w;
  vicr_ctx_type ctx_w;
  int n_fail, checked, gctl_m, base_m, lock_m, oneway_m, b, m;
  logic [AW-1:0] ra [11];

  vicr_core #(.PERIPH_N(8), .LEGACY_LOW_VEC(LOW_VEC)) dut_u (
    .mclk_in(mclk_in), .nrst_in(nrst_r), .bus_in(bus_r),
    .rdata_out(rdata_w), .ext_pin_in(pin_r), .ext_high_in(ehi_r),
    .periph_req_in(preq_r), .periph_high_in(phi_r), .ack_in(ack_w),
    .ret_in(ret_r), .vec_out(vec_w), .ctx_out(ctx_w),
    .shadow_main_out(shm_w), .irq_out(irq_w));
  vicr_cpu_model cpu_u (.mclk_in(mclk_in), .nrst_in(nrst_r),
    .vec_in(vec_w), .wait_in(wait_r), .ack_out(ack_w));

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      n_fail++;
    end
  endtask : chk

  task automatic timeout();
    n_fail++;
    $display("wrong value at %0t: wait ran out", $time);
    print_verdict();
  endtask : timeout

  // ****************************************************************
  // register port
  // ****************************************************************
  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    bus_r <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
  endtask : wr

  task automatic idle();
    bus_r.wr <= 1'b0;
    @(posedge mclk_in);
  endtask : idle

  task automatic rd(input logic [AW-1:0] a, input int e);
    bus_r <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus_r.rd <= 1'b0;
    #1;
    chk(rdata_w, e & 'hff, "read data");
    @(posedge mclk_in);
  endtask : rd

  task automatic gw(input int g);
    wr(OFF_GCTL, 8'(g));
    idle();
    gctl_m = g;
  endtask : gw

  function automatic int gexp();
    int g;
    g = gctl_m & 'he7;
    if (g[5] == 1'b0) g[6] = 1'b0;
    return g;
  endfunction : gexp

  task automatic wbase(input int v);
    wr(OFF_BASE_L, 8'(v));
    wr(OFF_BASE_M, 8'(v >> 8));
    wr(OFF_BASE_U, 8'(v >> 16));
    idle();
    if (lock_m == 0) base_m = v;
  endtask : wbase

  task automatic rtrip(input logic [AW-1:0] o, input int v);
    rd(o, v);
    rd(AW'(o + 1), v >> 8);
    rd(AW'(o + 2), (v >> 16) & 'h1f);
  endtask : rtrip

  task automatic unlock(input int l, input int late);
    wr(OFF_KEY, KEY_FIRST);
    wr(OFF_KEY, KEY_SECOND);
    if (late != 0) idle();
    wr(OFF_LOCK, 8'(l));
    idle();
    if (late == 0 && !(oneway_m != 0 && lock_m != 0 && l == 0)) lock_m = l;
  endtask : unlock

  // ****************************************************************
  // cpu link
  // ****************************************************************
  task automatic take(input logic hi, input int ea, input vicr_ctx_type ec);
    int k;
    k = 0;
    wait_r <= 2'($urandom);
    @(posedge mclk_in);
    #1;
    while ((hi ? vec_w.take_high : vec_w.take_low) !== 1'b1) begin
      k++;
      if (k > 30) timeout();
      @(posedge mclk_in);
      #1;
    end
    chk(vec_w.addr, ea & 'h1fffff, "vector address");
    while (ack_w !== 1'b1) begin
      k++;
      if (k > 30) timeout();
      @(posedge mclk_in);
      #1;
    end
    @(posedge mclk_in);
    #1;
    chk(ctx_w, ec, "context after entry");
    @(posedge mclk_in);
  endtask : take

  task automatic ret(input vicr_ctx_type ec);
    ret_r <= 1'b1;
    @(posedge mclk_in);
    ret_r <= 1'b0;
    #1;
    chk(ctx_w, ec, "context after return");
    @(posedge mclk_in);
  endtask : ret

  task automatic no_take();
    repeat (4) @(posedge mclk_in);
    #1;
    chk({vec_w.take_high, vec_w.take_low}, 0, "vector offered");
  endtask : no_take

  task automatic do_reset();
    nrst_r <= 1'b0;
    repeat (10) @(posedge mclk_in);
    nrst_r <= 1'b1;
    @(posedge mclk_in);
    gctl_m = 'h07;
    base_m = 0;
    lock_m = 0;
    oneway_m = 0;
  endtask : do_reset

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    n_fail = 0;
    checked = 0;
    bus_r = '0;
    pin_r = 3'h0;
    ehi_r = 3'h0;
    preq_r = 8'h00;
    phi_r = 8'h00;
    ret_r = 1'b0;
    wait_r = 2'h0;
    nrst_r = 1'b0;
    void'($urandom(86599));
    ra = '{OFF_GCTL, OFF_STATE, OFF_LOCK, OFF_SHADOW, OFF_BASE_L, OFF_BASE_M,
           OFF_BASE_U, OFF_ADDR_L, OFF_ADDR_M, OFF_IRQ_STAT, 12'h123};
    @(posedge mclk_in);
    do_reset();
    foreach (ra[k]) rd(ra[k], (ra[k] == OFF_GCTL) ? 'h07 : 0);
    rd(OFF_ADDR_U, 0);
    repeat (4) begin
      gw($urandom & 'h7f);
      rd(OFF_GCTL, gexp());
    end
    for (int s = 1; s >= 0; s--) begin
      wr(OFF_SHADOW, 8'(s));
      idle();
      rd(OFF_SHADOW, s);
      chk(shm_w, s, "shadow select");
    end
    // one level: enable gates all, everything treated as high
    gw('h07);
    preq_r[0] <= 1'b1;
    no_take();
    gw('h87);
    take(1'b1, FIXED_VECTOR, CTX_HIGH_MAIN);
    preq_r[0] <= 1'b0;
    rd(OFF_STATE, 'h80);
    ret(CTX_MAIN);
    // two levels
    gw('ha7);
    preq_r[0] <= 1'b1;
    no_take();
    gw('h67);
    no_take();
    gw('he7);
    take(1'b0, LOW_VEC, CTX_LOW);
    rd(OFF_GCTL, gexp());
    preq_r <= 8'h02;
    phi_r <= 8'h02;
    take(1'b1, FIXED_VECTOR, CTX_HIGH_LOW);
    preq_r <= 8'h00;
    rd(OFF_STATE, 'hc0);
    ret(CTX_LOW);
    ret(CTX_MAIN);
    // table mode
    wr(OFF_CFG, 8'h01);
    b = $urandom & 'h1fffff;
    wbase(b);
    rtrip(OFF_BASE_L, base_m);
    gw('h87);
    preq_r[0] <= 1'b1;
    take(1'b1, base_m + 6, CTX_HIGH_MAIN);
    preq_r <= 8'h00;
    wr(OFF_ADDR_L, 8'hff);
    idle();
    rtrip(OFF_ADDR_L, base_m + 6);
    ret(CTX_MAIN);
    gw('h07);
    // lock
    wr(OFF_LOCK, 8'h01);
    idle();
    rd(OFF_LOCK, lock_m);
    unlock(1, 1);
    rd(OFF_LOCK, lock_m);
    unlock(1, 0);
    rd(OFF_LOCK, lock_m);
    wbase($urandom & 'h1fffff);
    rtrip(OFF_BASE_L, base_m);
    unlock(0, 0);
    rd(OFF_LOCK, lock_m);
    wbase($urandom & 'h1fffff);
    rtrip(OFF_BASE_L, base_m);
    wr(OFF_CFG, 8'h03);
    oneway_m = 1;
    unlock(1, 0);
    unlock(0, 0);
    rd(OFF_LOCK, lock_m);
    // external inputs, input 1 masked off
    wr(OFF_IRQ_MASK, 8'h05);
    m = 5;
    for (int i = 0; i < EXT_N; i++) begin
      b = $urandom % 2;
      gw(b != 0 ? 'h07 : 'h00);
      ehi_r <= 3'($urandom);
      pin_r[i] <= (b == 0);
      repeat (3) @(posedge mclk_in);
      rd(OFF_IRQ_STAT, 0);
      pin_r[i] <= (b != 0);
      repeat (2) @(posedge mclk_in);
      #1;
      chk(irq_w, (m >> i) & 1, "interrupt level");
      @(posedge mclk_in);
      rd(OFF_IRQ_STAT, 1 << i);
      #1;
      chk(irq_w, 0, "interrupt after clear");
      @(posedge mclk_in);
    end
    // second reset frees the one-way lock
    do_reset();
    rd(OFF_LOCK, 0);
    rtrip(OFF_BASE_L, 0);
    print_verdict();
  end
endmodule : vicr_core_tb
